/* File: hw/spec_error_capture.sv */
// Error capture and status registers of the first local-bus slave port.
// Assumes one-cycle register read/write strobes indexed by word, and
// queue and master error events as one-cycle pulses on the port clock.
module spec_error_capture (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Register port
	input wire logic [9:0] reg_index_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	input wire logic [31:0] reg_wdata_in,
	output logic [31:0] reg_rdata_out,
	output logic reg_ack_out,
	// Incoming command
	input wire spec_pkg::spec_cmd_t cmd_in,
	// Queue events, one bit per queue
	input wire logic [6:0] queue_overflow_in,
	input wire logic [6:0] queue_underflow_in,
	// Per-master error events
	input wire logic [3:0] slave_irq_in,
	input wire logic [3:0] posted_write_err_in,
	// Status to system
	input wire logic mode_wide_in,
	output logic [7:0] int_status_out,
	output logic [31:0] cfg_out,
	output logic [6:0] queue_reset_out,
	output logic cmd_reject_out
);

	// ****************************************
	// State
	// ****************************************
	logic [31:0] cfg_reg;
	logic [3:0] addr_high_reg;
	logic [31:0] addr_low_reg;
	spec_pkg::spec_qual_t qual_reg;
	logic [31:0] misc_flags_reg;
	logic [31:0] master_irq_reg;
	logic [31:0] rdata_next;
	spec_pkg::spec_check_t check;
	logic capture_event;
	logic capture_allow;
	logic wr_cfg;
	logic wr_qual;
	logic wr_flags;
	logic wr_irq;
	logic wr_ctrl;
	logic [31:0] queue_events;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic reg_hit(input logic [9:0] idx, input logic [9:0] target);
		reg_hit = (idx == target);
	endfunction

	function automatic logic [31:0] sticky_w1c(input logic [31:0] cur, input logic [31:0] set,
		input logic wr, input logic [31:0] data, input logic [31:0] mask);
		logic [31:0] clr;
		clr = wr ? data : spec_pkg::ZERO_WORD;
		// Set wins over a clear in the same cycle
		sticky_w1c = ((cur & ~clr) | set) & mask;
	endfunction

	assign wr_cfg = reg_write_in && reg_hit(reg_index_in, spec_pkg::IDX_CFG);
	assign wr_qual = reg_write_in && reg_hit(reg_index_in, spec_pkg::IDX_QUAL);
	assign wr_flags = reg_write_in && reg_hit(reg_index_in, spec_pkg::IDX_MISC_FLAGS);
	assign wr_irq = reg_write_in && reg_hit(reg_index_in, spec_pkg::IDX_MASTER_IRQ);
	assign wr_ctrl = reg_write_in && reg_hit(reg_index_in, spec_pkg::IDX_MISC_CTRL);

	// ****************************************
	// Command check
	// ****************************************
	spec_cmd_check u_check (
		.cmd_in(cmd_in),
		.posting_en_in(cfg_reg[spec_pkg::CFG_POSTING]),
		.size_chk_dis_in(cfg_reg[spec_pkg::CFG_SIZE_CHK_DIS]),
		.addr_log_en_in(cfg_reg[spec_pkg::CFG_ADDR_LOG]),
		.check_out(check)
	);

	assign capture_event = check.failed || (cmd_in.valid && cmd_in.sniff_match);
	assign capture_allow = !cfg_reg[spec_pkg::CFG_HOLD_FIRST] || !qual_reg.record_valid;

	// ****************************************
	// Configuration
	// ****************************************
	// logging and check controls
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cfg_reg <= spec_pkg::CFG_RESET;
		end else if (wr_cfg) begin
			cfg_reg <= reg_wdata_in;
		end
	end

	// ****************************************
	// Captured record
	// ****************************************
	// sticky record, reset zero
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			addr_high_reg <= 4'h0;
			addr_low_reg <= spec_pkg::ZERO_WORD;
			qual_reg <= '0;
		end else if (capture_event && capture_allow) begin
			addr_low_reg <= cmd_in.addr[31:0];
			addr_high_reg <= cmd_in.addr[35:32];
			qual_reg.byte_lane_enables <= cmd_in.byte_lane_enables;
			qual_reg.size <= cmd_in.size;
			qual_reg.read_not_write <= cmd_in.read_not_write;
			qual_reg.xfer_type <= cmd_in.xfer_type;
			qual_reg.master_width <= cmd_in.master_width;
			qual_reg.master_id <= cmd_in.master_id;
			qual_reg.reserved <= 2'h0;
			qual_reg.master_lock_error <= cmd_in.lock_error;
			qual_reg.record_valid <= 1'b1;
		end else if (wr_qual) begin
			qual_reg <= '0;
			addr_low_reg <= spec_pkg::ZERO_WORD;
			addr_high_reg <= 4'h0;
		end
	end

	// ****************************************
	// Status flags
	// ****************************************
	// queue flag pairs
	always_comb begin
		queue_events = spec_pkg::ZERO_WORD;
		for (int i = 0; i < spec_pkg::NUM_QUEUES; i++) begin
			queue_events[spec_pkg::FLG_QUEUE_LO + 2 * i] = queue_overflow_in[i];
			queue_events[spec_pkg::FLG_QUEUE_LO + 2 * i + 1] = queue_underflow_in[i];
		end
		queue_events[spec_pkg::FLG_POST_CFG] = check.posting_error;
		queue_events[spec_pkg::FLG_ILLEGAL] = check.illegal;
		queue_events[spec_pkg::FLG_ADDR] = cmd_in.valid && cmd_in.addr_mismatch
			&& cfg_reg[spec_pkg::CFG_ADDR_LOG];
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			misc_flags_reg <= spec_pkg::ZERO_WORD;
		end else begin
			misc_flags_reg <= sticky_w1c(misc_flags_reg, queue_events, wr_flags, reg_wdata_in,
				spec_pkg::MISC_FLAGS_MASK);
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			master_irq_reg <= spec_pkg::ZERO_WORD;
		end else begin
			master_irq_reg <= sticky_w1c(master_irq_reg,
				{slave_irq_in | posted_write_err_in, 28'h0000000}, wr_irq, reg_wdata_in,
				spec_pkg::MASTER_IRQ_MASK);
		end
	end

	// ****************************************
	// Interrupt status and outputs
	// ****************************************
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			int_status_out <= 8'h00;
		end else begin
			int_status_out <= 8'h00;
			int_status_out[spec_pkg::INT_CMD_ERR] <= |misc_flags_reg[spec_pkg::FLG_ADDR:spec_pkg::FLG_POST_CFG];
			int_status_out[spec_pkg::INT_QUEUE_ERR] <=
				|misc_flags_reg[spec_pkg::FLG_QUEUE_LO +: 2 * spec_pkg::NUM_QUEUES];
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cfg_out <= spec_pkg::CFG_RESET;
			queue_reset_out <= 7'h00;
			cmd_reject_out <= 1'b0;
		end else begin
			cfg_out <= wr_cfg ? reg_wdata_in : cfg_reg;
			queue_reset_out <= wr_ctrl ? reg_wdata_in[spec_pkg::CTRL_QUEUE_RST_LO +: spec_pkg::NUM_QUEUES] : 7'h00;
			cmd_reject_out <= check.failed;
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	always_comb begin
		rdata_next = spec_pkg::ZERO_WORD;
		unique case (reg_index_in)
			spec_pkg::IDX_CFG: rdata_next = cfg_reg;
			spec_pkg::IDX_ADDR_HIGH: rdata_next = {28'h0000000, addr_high_reg};
			spec_pkg::IDX_ADDR_LOW: rdata_next = addr_low_reg;
			spec_pkg::IDX_QUAL: rdata_next = qual_reg;
			spec_pkg::IDX_MISC_FLAGS: rdata_next = misc_flags_reg;
			spec_pkg::IDX_MASTER_IRQ: rdata_next = master_irq_reg;
			spec_pkg::IDX_FSM_VIEW: rdata_next = spec_pkg::ZERO_WORD;
			spec_pkg::IDX_MISC_CTRL: rdata_next = {31'h00000000, mode_wide_in} & spec_pkg::CTRL_READ_MASK;
			default: rdata_next = spec_pkg::ZERO_WORD;
		endcase
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			reg_rdata_out <= spec_pkg::ZERO_WORD;
			reg_ack_out <= 1'b0;
		end else begin
			reg_rdata_out <= reg_read_in ? rdata_next : spec_pkg::ZERO_WORD;
			reg_ack_out <= reg_read_in || reg_write_in;
		end
	end

endmodule

/* File: hw/spec_pkg.sv */
// Package for the slave port error capture block: register map, field layouts, types.
// Assumes a DCR-style register port with a word index, one-cycle strobes, 32-bit data.
// Summary of operation
// - Failed transaction captures low 32 address bits
// - Qualifier register write clears low address
// - Failure is address mismatch (only with logging on) or illegal command
// - Only single, line 4/8/16, bursts legal
// - No posting: line or burst is illegal
// - Bit 0 valid marks meaningful record
// - Hold-first-error captures only while not valid
// - Qualifier write clears whole register
// - Qualifier field layout fixed as documented
// - Status flags clear by writing one
// - Interrupt bit 3 from config/illegal/mismatch
// - Interrupt bit 7 from any queue flag
// - Status bit 0 on posting config error
// - Status bit 1 illegal size, unless disabled
// - Status bit 2 mismatch, gated by logging
// - Queue overflow/underflow pairs in bits 18-31
// - Per-master error irq bits 28:31
// - State view register reads all zero
// - Write-only control bits read zero
// - Sniffer matches share capture path
// - Upper nibble captured in upper register
// - Cfg bit 30 logs, bit 31 disables check
package spec_pkg;

	// ****************************************
	// Register indices
	// ****************************************
	localparam logic [9:0] IDX_CFG = 10'h034;
	localparam logic [9:0] IDX_ADDR_HIGH = 10'h036;
	localparam logic [9:0] IDX_ADDR_LOW = 10'h037;
	localparam logic [9:0] IDX_QUAL = 10'h038;
	localparam logic [9:0] IDX_MISC_FLAGS = 10'h039;
	localparam logic [9:0] IDX_MASTER_IRQ = 10'h03A;
	localparam logic [9:0] IDX_FSM_VIEW = 10'h03B;
	localparam logic [9:0] IDX_MISC_CTRL = 10'h03C;

	// ****************************************
	// Field positions (bit 0 is the LSB here)
	// ****************************************
	localparam int CFG_HOLD_FIRST = 0;
	localparam int CFG_POSTING = 28;
	localparam int CFG_ADDR_LOG = 30;
	localparam int CFG_SIZE_CHK_DIS = 31;
	localparam int FLG_POST_CFG = 0;
	localparam int FLG_ILLEGAL = 1;
	localparam int FLG_ADDR = 2;
	localparam int FLG_QUEUE_LO = 18;
	localparam int IRQ_MASTER_LO = 28;
	localparam int CTRL_QUEUE_RST_LO = 25;
	localparam int INT_CMD_ERR = 3;
	localparam int INT_QUEUE_ERR = 7;
	localparam int NUM_QUEUES = 7;
	localparam int NUM_MASTERS = 4;

	// ****************************************
	// Reset values and masks
	// ****************************************
	localparam logic [31:0] CFG_RESET = 32'h3600_0000;
	localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
	localparam logic [31:0] MISC_FLAGS_MASK = 32'hFFFC_0007;
	localparam logic [31:0] MASTER_IRQ_MASK = 32'hF000_0000;
	localparam logic [31:0] CTRL_READ_MASK = 32'h0000_0001;
	localparam logic [31:0] CTRL_WO_MASK = 32'hFE00_0000;
	localparam logic [3:0] SIZE_SINGLE = 4'h0;
	localparam logic [3:0] SIZE_LINE4 = 4'h1;
	localparam logic [3:0] SIZE_LINE8 = 4'h2;
	localparam logic [3:0] SIZE_LINE16 = 4'h3;
	localparam logic [3:0] SIZE_BURST32 = 4'hA;
	localparam logic [3:0] SIZE_BURST64 = 4'hB;
	localparam logic [3:0] SIZE_BURST128 = 4'hC;
	localparam logic [2:0] TYPE_MEMORY = 3'h0;

	// ****************************************
	// Types
	// ****************************************
	typedef struct packed {
		logic [15:0] byte_lane_enables;
		logic [3:0] size;
		logic read_not_write;
		logic [2:0] xfer_type;
		logic [1:0] master_width;
		logic [1:0] master_id;
		logic [1:0] reserved;
		logic master_lock_error;
		logic record_valid;
	} spec_qual_t;

	typedef struct packed {
		logic valid;
		logic [35:0] addr;
		logic addr_mismatch;
		logic sniff_match;
		logic lock_error;
		logic [1:0] master_id;
		logic [1:0] master_width;
		logic [2:0] xfer_type;
		logic read_not_write;
		logic [3:0] size;
		logic [15:0] byte_lane_enables;
	} spec_cmd_t;

	typedef struct packed {
		logic illegal;
		logic posting_error;
		logic failed;
	} spec_check_t;

endpackage

/* File: hw/spec_cmd_check.sv */
// Combinational command legality check for the slave port.
// Assumes the command fields are stable while valid is high.
module spec_cmd_check (
	// Command
	input wire spec_pkg::spec_cmd_t cmd_in,
	// Configuration
	input wire logic posting_en_in,
	input wire logic size_chk_dis_in,
	input wire logic addr_log_en_in,
	// Result
	output spec_pkg::spec_check_t check_out
);

	logic size_legal;
	logic is_single;

	always_comb begin
		unique case (cmd_in.size)
			spec_pkg::SIZE_SINGLE, spec_pkg::SIZE_LINE4, spec_pkg::SIZE_LINE8, spec_pkg::SIZE_LINE16,
			spec_pkg::SIZE_BURST32, spec_pkg::SIZE_BURST64, spec_pkg::SIZE_BURST128: size_legal = 1'b1;
			default: size_legal = 1'b0;
		endcase
	end

	assign is_single = (cmd_in.size == spec_pkg::SIZE_SINGLE);

	always_comb begin
		check_out.posting_error = cmd_in.valid && !posting_en_in && !is_single && !size_chk_dis_in;
		check_out.illegal = cmd_in.valid && !size_legal && !size_chk_dis_in;
		check_out.failed = check_out.illegal || check_out.posting_error
			|| (cmd_in.valid && cmd_in.addr_mismatch && addr_log_en_in);
	end

endmodule

/* File: test/spec_cmd_master.sv */
// Local-bus master model feeding commands into the slave port.
// Assumes send() is called from the bench and drives off the falling edge.
module spec_cmd_master (
	// Clock
	input wire logic clk_in,
	// Command
	output spec_pkg::spec_cmd_t cmd_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cmd_out = '0;
	end
	task automatic send(input logic [35:0] a, input logic [3:0] sz, input logic mm, input logic sn);
		spec_pkg::spec_cmd_t c;
		c = {1'b1, a, mm, sn, 1'b1, 2'h2, 2'h1, 3'h0, 1'b1, sz, 16'hA5C3};
		c.xfer_type = spec_pkg::TYPE_MEMORY;
		@(negedge clk_in);
		cmd_out = c;
		@(negedge clk_in);
		// Idle: fields scrambled, valid low
		cmd_out = ~c;
	endtask
endmodule

/* File: test/spec_error_capture_props.sv */
// Port-level assertions for the slave port error capture block.
// Assumes binding to spec_error_capture; one clock domain.
module spec_error_capture_props (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Observed ports
	input wire logic [9:0] reg_index_in,
	input wire logic reg_write_in,
	input wire logic reg_read_in,
	input wire logic [31:0] reg_rdata_out,
	input wire spec_pkg::spec_cmd_t cmd_in,
	input wire logic [6:0] queue_overflow_in,
	input wire logic [7:0] int_status_out,
	input wire logic [31:0] cfg_out,
	input wire logic cmd_reject_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic legal;
	assign legal = cmd_in.size <= 4'h3 || (cmd_in.size >= 4'hA && cmd_in.size <= 4'hC);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	sequence s_bad_size;
		cmd_in.valid && !legal && !cfg_out[31];
	endsequence
	sequence s_no_post;
		cmd_in.valid && !cfg_out[28] && cmd_in.size != 4'h0 && !cfg_out[31];
	endsequence
	a_illegal_rejected: assert property (s_bad_size |=> cmd_reject_out)
		else $error("illegal size passed");
	a_illegal_summary: assert property (s_bad_size |-> ##2 int_status_out[3])
		else $error("command summary missing");
	a_posting_rejected: assert property (s_no_post |=> cmd_reject_out)
		else $error("posting error passed");
	a_mismatch_logged: assert property (cmd_in.valid && cmd_in.addr_mismatch && cfg_out[30] |=> cmd_reject_out)
		else $error("mismatch passed");
	a_legal_accepted: assert property (cmd_in.valid && legal && cfg_out[28] && !cmd_in.addr_mismatch
		|=> !cmd_reject_out)
		else $error("legal command refused");
	a_check_disabled: assert property (cmd_in.valid && cfg_out[31] && !cmd_in.addr_mismatch
		|=> !cmd_reject_out)
		else $error("disabled check refused");
	a_queue_summary: assert property (queue_overflow_in != 7'h00 |-> ##2 int_status_out[7])
		else $error("queue summary missing");
	a_state_view_zero: assert property (reg_read_in && reg_index_in == spec_pkg::IDX_FSM_VIEW
		|=> reg_rdata_out == 32'h0000_0000)
		else $error("state view not zero");
	a_ctrl_wo_zero: assert property (reg_read_in && reg_index_in == spec_pkg::IDX_MISC_CTRL
		|=> (reg_rdata_out & spec_pkg::CTRL_WO_MASK) == 32'h0000_0000)
		else $error("write-only bits read back");
	a_flags_sticky: assert property (int_status_out[7] && !reg_write_in && !$past(reg_write_in)
		|=> int_status_out[7])
		else $error("queue flag dropped");
endmodule
bind spec_error_capture spec_error_capture_props u_props (.clk_in(clk_in), .rst_in(rst_in),
	.reg_index_in(reg_index_in), .reg_write_in(reg_write_in), .reg_read_in(reg_read_in),
	.reg_rdata_out(reg_rdata_out), .cmd_in(cmd_in), .queue_overflow_in(queue_overflow_in),
	.int_status_out(int_status_out), .cfg_out(cfg_out), .cmd_reject_out(cmd_reject_out));

/* File: test/tb_slave_port_error_capture.sv */
// Self-checking bench for the slave port error capture block.
// Assumes the design package and the command master model are compiled first.
module tb_slave_port_error_capture;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [31:0] cfg;
		logic [3:0] size;
		logic mm;
		logic rej;
		logic [2:0] flg;
	} spec_row_t;
	localparam logic [9:0] R_CFG = spec_pkg::IDX_CFG;
	localparam logic [9:0] R_AH = spec_pkg::IDX_ADDR_HIGH;
	localparam logic [9:0] R_AL = spec_pkg::IDX_ADDR_LOW;
	localparam logic [9:0] R_QL = spec_pkg::IDX_QUAL;
	localparam logic [9:0] R_FL = spec_pkg::IDX_MISC_FLAGS;
	localparam logic [9:0] R_MI = spec_pkg::IDX_MASTER_IRQ;
	localparam logic [9:0] R_MC = spec_pkg::IDX_MISC_CTRL;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic [9:0] idx = 10'h000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [6:0] q_of = 7'h00;
	logic [6:0] q_uf = 7'h00;
	logic [3:0] s_irq = 4'h0;
	logic [3:0] p_err = 4'h0;
	logic [31:0] rdata;
	logic [31:0] cfg;
	logic [31:0] got;
	logic [7:0] ints;
	logic [6:0] q_rst;
	logic ack;
	logic rej;
	spec_pkg::spec_cmd_t cmd;
	int fail_count = 0;
	int checked = 0;
	spec_row_t rows [7] = '{'{32'h3600_0000, 4'h5, 1'b0, 1'b1, 3'h2}, '{32'h3600_0000, 4'h0, 1'b1, 1'b0, 3'h0},
		'{32'h7600_0000, 4'h0, 1'b1, 1'b1, 3'h4}, '{32'h2600_0000, 4'h0, 1'b0, 1'b0, 3'h0},
		'{32'h2600_0000, 4'hA, 1'b0, 1'b1, 3'h1}, '{32'hB600_0000, 4'h5, 1'b0, 1'b0, 3'h0},
		'{32'hA600_0000, 4'h3, 1'b0, 1'b0, 3'h0}};
	spec_error_capture uut (.clk_in(clk_in), .rst_in(rst_in), .reg_index_in(idx), .reg_write_in(wr),
		.reg_read_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .reg_ack_out(ack), .cmd_in(cmd),
		.queue_overflow_in(q_of), .queue_underflow_in(q_uf), .slave_irq_in(s_irq),
		.posted_write_err_in(p_err), .mode_wide_in(1'b1), .int_status_out(ints), .cfg_out(cfg),
		.queue_reset_out(q_rst), .cmd_reject_out(rej));
	spec_cmd_master mst (.clk_in(clk_in), .cmd_out(cmd));
	initial begin
		forever #20 clk_in = ~clk_in;
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic reg_op(input logic [9:0] i, input logic w, input logic [31:0] d);
		@(negedge clk_in);
		idx = i;
		wr = w;
		rd = !w;
		wdata = d;
		@(negedge clk_in);
		wr = 1'b0;
		rd = 1'b0;
		got = rdata;
	endtask
	task automatic rd_chk(input logic [9:0] i, input logic [31:0] exp);
		reg_op(i, 1'b0, 32'h0);
		chk(got, exp);
	endtask
	task automatic pulse(input logic [6:0] o, input logic [6:0] u, input logic [3:0] s, input logic [3:0] p);
		@(negedge clk_in);
		q_of = o;
		q_uf = u;
		s_irq = s;
		p_err = p;
		@(negedge clk_in);
		q_of = 7'h00;
		q_uf = 7'h00;
		s_irq = 4'h0;
		p_err = 4'h0;
	endtask
	task automatic end_of_test();
		$display("Comparisons %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk_in);
		fail_count++;
		end_of_test();
	end
	initial begin
		repeat (3) @(posedge clk_in);
		@(negedge clk_in);
		rst_in = 1'b0;
		foreach (rows[n]) begin
			reg_op(R_CFG, 1'b1, rows[n].cfg);
			reg_op(R_FL, 1'b1, 32'hFFFF_FFFF);
			mst.send(36'h1_0000_0040, rows[n].size, rows[n].mm, 1'b0);
			chk({31'h0, rej}, {31'h0, rows[n].rej});
			rd_chk(R_FL, {29'h0, rows[n].flg});
			chk({24'h0, ints}, {24'h0, 4'h0, |rows[n].flg, 3'h0});
		end
		reg_op(R_CFG, 1'b1, spec_pkg::CFG_RESET);
		for (int s = 0; s < 16; s++) begin
			mst.send(36'h0_0000_0100, s[3:0], 1'b0, 1'b0);
			chk({31'h0, rej}, {31'h0, !(s < 4 || (s > 9 && s < 13))});
		end
		reg_op(R_QL, 1'b1, 32'h0);
		mst.send(36'h9_1234_5678, 4'h5, 1'b0, 1'b0);
		rd_chk(R_QL, {16'hA5C3, 4'h5, 1'b1, 3'h0, 2'h1, 2'h2, 2'h0, 1'b1, 1'b1});
		rd_chk(R_AL, 32'h1234_5678);
		rd_chk(R_AH, 32'h0000_0009);
		reg_op(R_CFG, 1'b1, 32'h3600_0001);
		mst.send(36'h0_0BAD_0000, 4'h5, 1'b0, 1'b0);
		rd_chk(R_AL, 32'h1234_5678);
		reg_op(R_QL, 1'b1, 32'hFFFF_FFFF);
		rd_chk(R_QL, 32'h0);
		rd_chk(R_AL, 32'h0);
		mst.send(36'h0_0BAD_0000, 4'h5, 1'b0, 1'b0);
		rd_chk(R_AL, 32'h0BAD_0000);
		rd_chk(R_QL, {16'hA5C3, 4'h5, 1'b1, 3'h0, 2'h1, 2'h2, 2'h0, 1'b1, 1'b1});
		reg_op(R_CFG, 1'b1, spec_pkg::CFG_RESET);
		mst.send(36'h0_5EED_0004, 4'h1, 1'b0, 1'b1);
		rd_chk(R_AL, 32'h5EED_0004);
		for (int i = 0; i < 7; i++) begin
			reg_op(R_FL, 1'b1, 32'hFFFF_FFFF);
			pulse(7'(1 << i), 7'(7'h40 >> i), 4'h0, 4'h0);
			rd_chk(R_FL, (32'h1 << (18 + 2 * i)) | (32'h1 << (31 - 2 * i)));
		end
		chk({24'h0, ints}, 32'h0000_0080);
		reg_op(R_FL, 1'b1, 32'h4000_0000);
		rd_chk(R_FL, 32'h0008_0000);
		pulse(7'h00, 7'h00, 4'h1, 4'h8);
		rd_chk(R_MI, 32'h9000_0000);
		reg_op(R_MI, 1'b1, 32'h1000_0000);
		rd_chk(R_MI, 32'h8000_0000);
		reg_op(R_MC, 1'b1, 32'hFE00_0000);
		chk({25'h0, q_rst}, 32'h7F);
		chk({31'h0, ack}, 32'h1);
		rd_chk(R_MC, 32'h0000_0001);
		rd_chk(spec_pkg::IDX_FSM_VIEW, 32'h0);
		rd_chk(10'h03F, 32'h0);
		reg_op(R_CFG, 1'b1, 32'h7600_0001);
		@(negedge clk_in);
		rst_in = 1'b1;
		@(negedge clk_in);
		rst_in = 1'b0;
		chk(cfg, spec_pkg::CFG_RESET);
		rd_chk(R_CFG, spec_pkg::CFG_RESET);
		rd_chk(R_FL, 32'h0);
		rd_chk(R_MI, 32'h0);
		rd_chk(R_QL, 32'h0);
		end_of_test();
	end
endmodule
